// ==== design/pmrm_consts.vh ====
// constants of the power monitor register map
`ifndef PMRM_CONSTS_VH
`define PMRM_CONSTS_VH
// register indices (word addresses)
`define PMRM_ADDR_SETUP      6'h00
`define PMRM_ADDR_CONV       6'h01
`define PMRM_ADDR_BUS_VOLTAGE_RESULT       6'h05
`define PMRM_ADDR_TEMP       6'h06
`define PMRM_ADDR_CURR       6'h07
`define PMRM_ADDR_POWER      6'h08
`define PMRM_ADDR_ENERGY     6'h09
`define PMRM_ADDR_CHARGE     6'h0A
`define PMRM_ADDR_FAULT      6'h0B
`define PMRM_ADDR_LIM_FIRST  6'h0C
`define PMRM_ADDR_LIM_LAST   6'h11
`define PMRM_ADDR_IDENT      6'h3E
// setup register fields
`define PMRM_BIT_FULL_RESET  15
`define PMRM_BIT_ACC_CLEAR   14
`define PMRM_DLY_MSB         13
`define PMRM_DLY_LSB         6
`define PMRM_SETUP_FIXED     16'h0010
// reset values
`define PMRM_CONV_RESET      16'hFB68
`define PMRM_LIMIT_RESET     16'h0000
// arbitrary neutral maker code
`define PMRM_IDENT_CODE      16'h5A5A
// start delay timing
`define PMRM_DLY_STEP_NS     2000000
`define PMRM_CLK_NS          25
`define PMRM_DLY_STEP_CYC    (`PMRM_DLY_STEP_NS / `PMRM_CLK_NS)
`endif

// ==== design/pmrm_limit_bank.v ====
// bank of six 16-bit alert limit registers
`timescale 1ns/10ps
`include "pmrm_consts.vh"
module pmrm_limit_bank (
  input  wire         i_clk,
  input  wire         i_rst_n,
  input  wire         i_ce,
  input  wire         i_soft_rst,
  input  wire         i_wr,
  input  wire [2:0]   i_sel,
  input  wire [15:0]  i_wdata,
  output wire [95:0]  o_limits
);
  genvar g;
  // ******************************
  // one register per limit
  // ******************************
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_lim
      reg [15:0] value;
      // limits revert to default on any reset
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          value <= `PMRM_LIMIT_RESET;
        end else if (i_ce) begin
          if (i_soft_rst) begin
            value <= `PMRM_LIMIT_RESET;
          end else if (i_wr && (i_sel == g)) begin
            value <= i_wdata;
          end
        end
      end
      assign o_limits[g*16 +: 16] = value;
    end
  endgenerate
endmodule // pmrm_limit_bank

// ==== design/pmrm_start_delay.v ====
// initial conversion delay timer in 2 ms steps
`timescale 1ns/10ps
`include "pmrm_consts.vh"
module pmrm_start_delay (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_ce,
  input  wire        i_restart,
  input  wire [7:0]  i_steps,
  output reg         o_done
);
  // step length in clock cycles, cut to the counter width on purpose
  localparam integer STEP_CYC_FULL = `PMRM_DLY_STEP_CYC;
  localparam [23:0]  STEP_CYC      = STEP_CYC_FULL[23:0];
  reg [23:0] cycles;
  reg [7:0]  steps;
  reg        armed;
  // ******************************
  // step counter
  // ******************************
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cycles <= 24'h000000;
      steps  <= 8'h00;
      armed  <= 1'b1;
      o_done <= 1'b0;
    end else if (i_ce) begin
      if (i_restart) begin
        cycles <= 24'h000000;
        steps  <= 8'h00;
        armed  <= 1'b1;
        o_done <= 1'b0;
      end else if (armed) begin
        // code zero: no delay; each code adds 2 ms
        if (steps >= i_steps) begin
          armed  <= 1'b0;
          o_done <= 1'b1;
        end else if (cycles == STEP_CYC - 24'h000001) begin
          cycles <= 24'h000000;
          steps  <= steps + 8'h01;
        end else begin
          cycles <= cycles + 24'h000001;
        end
      end
    end
  end
endmodule // pmrm_start_delay

// ==== design/pmrm_top.v ====
// register map of the current, voltage and power monitor
//
// Summary of operation
// - writing one to setup bit 15 resets all registers; bit self-clears.
// - writing one to setup bit 14 zeroes energy and charge accumulators.
// - setup bits 13..6 delay first conversion by 2 ms per code.
// - setup bit 4 reads one; bits 5 and 3..0 read zero.
// - converter setup at address 1 resets to FB68 hex.
// - read-only identification register at 3E hex gives fixed maker code.
// - die temperature result is a 16-bit register at address 6.
// - alert limits return to defaults on every power cycle.
`timescale 1ns/10ps
`include "pmrm_consts.vh"
module pmrm_top (
  input  wire         I_SYS_CLK,
  input  wire         I_RST_N,
  input  wire         I_CE,
  input  wire [5:0]   I_ADDR,
  input  wire [15:0]  I_WDATA,
  input  wire         I_WR,
  input  wire         I_RD,
  input  wire [15:0]  I_BUS_VOLTAGE_RESULT,
  input  wire [15:0]  I_TEMP,
  input  wire [15:0]  I_CURR,
  input  wire [23:0]  I_POWER,
  input  wire [39:0]  I_ENERGY_INC,
  input  wire [39:0]  I_CHARGE_INC,
  input  wire         I_SAMPLE,
  input  wire [15:0]  I_FAULT,
  output reg  [39:0]  O_RDATA,
  output reg  [15:0]  O_CONV_SETUP,
  output reg          O_CONV_ENABLE,
  output reg  [95:0]  O_LIMITS
);
  // ******************************
  // state
  // ******************************
  reg         soft_rst;
  reg         acc_clear;
  reg  [7:0]  start_delay;
  reg  [15:0] conv_setup;
  reg  [15:0] res_bus_voltage_result;
  reg  [15:0] res_temp;
  reg  [15:0] res_curr;
  reg  [23:0] res_power;
  reg  [39:0] energy;
  reg  [39:0] charge;
  reg  [15:0] fault_flags;
  reg  [39:0] next_rdata;
  wire [95:0] limits;
  wire        delay_done;
  wire        wr_setup;
  wire        lim_hit;
  wire [5:0]  lim_off;
  wire        wr_conv;
  wire        take_sample;

  assign wr_setup = I_WR && (I_ADDR == `PMRM_ADDR_SETUP);
  assign lim_hit  = (I_ADDR >= `PMRM_ADDR_LIM_FIRST) && (I_ADDR <= `PMRM_ADDR_LIM_LAST);
  assign lim_off  = I_ADDR - `PMRM_ADDR_LIM_FIRST;
  assign wr_conv  = I_WR && (I_ADDR == `PMRM_ADDR_CONV);
  // results are taken only once the start delay has expired
  assign take_sample = I_SAMPLE && delay_done;

  // ******************************
  // setup register: self-clearing strobes
  // ******************************
  // full reset like power-on; lives one cycle, then clears itself
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      soft_rst <= 1'b0;
    end else if (I_CE) begin
      if (soft_rst) begin
        soft_rst <= 1'b0;
      end else if (wr_setup) begin
        soft_rst <= I_WDATA[`PMRM_BIT_FULL_RESET];
      end
    end
  end

  // accumulator clear; a one-cycle pulse, never read back
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      acc_clear <= 1'b0;
    end else if (I_CE) begin
      if (soft_rst) begin
        acc_clear <= 1'b0;
      end else if (wr_setup) begin
        acc_clear <= I_WDATA[`PMRM_BIT_ACC_CLEAR];
      end else begin
        acc_clear <= 1'b0;
      end
    end
  end

  // ******************************
  // setup register: start delay code
  // ******************************
  // code kept for read-back and for the delay timer
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      start_delay <= 8'h00;
    end else if (I_CE) begin
      if (soft_rst) begin
        start_delay <= 8'h00;
      end else if (wr_setup) begin
        start_delay <= I_WDATA[`PMRM_DLY_MSB:`PMRM_DLY_LSB];
      end
    end
  end

  // ******************************
  // converter setup register
  // ******************************
  // writes during the full reset cycle are lost, the default wins
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      conv_setup <= `PMRM_CONV_RESET;
    end else if (I_CE) begin
      if (soft_rst) begin
        conv_setup <= `PMRM_CONV_RESET;
      end else if (wr_conv) begin
        conv_setup <= I_WDATA;
      end
    end
  end

  // ******************************
  // measurement results
  // ******************************
  // bus voltage result
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      res_bus_voltage_result <= 16'h0000;
    end else if (I_CE) begin
      if (soft_rst) begin
        res_bus_voltage_result <= 16'h0000;
      end else if (take_sample) begin
        res_bus_voltage_result <= I_BUS_VOLTAGE_RESULT;
      end
    end
  end

  // die temperature result; the low four bits always read zero
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      res_temp <= 16'h0000;
    end else if (I_CE) begin
      if (soft_rst) begin
        res_temp <= 16'h0000;
      end else if (take_sample) begin
        res_temp <= {I_TEMP[15:4], 4'h0};
      end
    end
  end

  // current result
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      res_curr <= 16'h0000;
    end else if (I_CE) begin
      if (soft_rst) begin
        res_curr <= 16'h0000;
      end else if (take_sample) begin
        res_curr <= I_CURR;
      end
    end
  end

  // power result, 24 bits wide
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      res_power <= 24'h000000;
    end else if (I_CE) begin
      if (soft_rst) begin
        res_power <= 24'h000000;
      end else if (take_sample) begin
        res_power <= I_POWER;
      end
    end
  end

  // fault flags, copied from the converter with each result
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fault_flags <= 16'h0000;
    end else if (I_CE) begin
      if (soft_rst) begin
        fault_flags <= 16'h0000;
      end else if (take_sample) begin
        fault_flags <= I_FAULT;
      end
    end
  end

  // ******************************
  // energy and charge accumulators
  // ******************************
  // a clear wins over an increment that falls in the same cycle
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      energy <= 40'h0000000000;
    end else if (I_CE) begin
      if (soft_rst) begin
        energy <= 40'h0000000000;
      end else if (acc_clear) begin
        energy <= 40'h0000000000;
      end else if (take_sample) begin
        energy <= energy + I_ENERGY_INC; // wraps at 40 bits
      end
    end
  end

  // charge accumulator, cleared the same way as energy
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      charge <= 40'h0000000000;
    end else if (I_CE) begin
      if (soft_rst) begin
        charge <= 40'h0000000000;
      end else if (acc_clear) begin
        charge <= 40'h0000000000;
      end else if (take_sample) begin
        charge <= charge + I_CHARGE_INC; // wraps at 40 bits
      end
    end
  end

  // ******************************
  // read mux, data one cycle after strobe
  // ******************************
  always @* begin
    next_rdata = 40'h0000000000; // unlisted addresses read zero
    case (I_ADDR)
      `PMRM_ADDR_SETUP:  next_rdata = {24'h000000, 1'b0, 1'b0, start_delay, 6'h00}
                                      | {24'h000000, `PMRM_SETUP_FIXED};
      `PMRM_ADDR_CONV:   next_rdata = {24'h000000, conv_setup};
      `PMRM_ADDR_BUS_VOLTAGE_RESULT:   next_rdata = {24'h000000, res_bus_voltage_result};
      `PMRM_ADDR_TEMP:   next_rdata = {24'h000000, res_temp};
      `PMRM_ADDR_CURR:   next_rdata = {24'h000000, res_curr};
      `PMRM_ADDR_POWER:  next_rdata = {16'h0000, res_power};
      `PMRM_ADDR_ENERGY: next_rdata = energy;
      `PMRM_ADDR_CHARGE: next_rdata = charge;
      `PMRM_ADDR_FAULT:  next_rdata = {24'h000000, fault_flags};
      `PMRM_ADDR_IDENT:  next_rdata = {24'h000000, `PMRM_IDENT_CODE};
      default: begin
        if (lim_hit) begin
          next_rdata = {24'h000000, limits[lim_off[2:0]*16 +: 16]};
        end
      end
    endcase
  end

  // ******************************
  // registered outputs
  // ******************************
  // read data stand one cycle after the strobe, zero otherwise
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RDATA <= 40'h0000000000;
    end else if (I_CE) begin
      O_RDATA <= I_RD ? next_rdata : 40'h0000000000;
    end
  end

  // copy of the converter setup for the converter
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CONV_SETUP <= `PMRM_CONV_RESET;
    end else if (I_CE) begin
      O_CONV_SETUP <= conv_setup;
    end
  end

  // converter runs once the start delay has expired
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CONV_ENABLE <= 1'b0;
    end else if (I_CE) begin
      O_CONV_ENABLE <= delay_done && !soft_rst;
    end
  end

  // copy of the alert limits
  always @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_LIMITS <= 96'h0;
    end else if (I_CE) begin
      O_LIMITS <= limits;
    end
  end

  // ******************************
  // submodules
  // ******************************
  pmrm_limit_bank u_limits (
    .i_clk      (I_SYS_CLK),
    .i_rst_n    (I_RST_N),
    .i_ce       (I_CE),
    .i_soft_rst (soft_rst),
    .i_wr       (I_WR && lim_hit),
    .i_sel      (lim_off[2:0]),
    .i_wdata    (I_WDATA),
    .o_limits   (limits)
  );

  pmrm_start_delay u_delay (
    .i_clk     (I_SYS_CLK),
    .i_rst_n   (I_RST_N),
    .i_ce      (I_CE),
    .i_restart (soft_rst || wr_setup),
    .i_steps   (wr_setup ? I_WDATA[`PMRM_DLY_MSB:`PMRM_DLY_LSB] : start_delay),
    .o_done    (delay_done)
  );
endmodule // pmrm_top

// ==== verification/pmrm_monitor.sv ====
// assertions on the register map ports
`timescale 1ns/10ps
`include "pmrm_consts.vh"
module pmrm_monitor (
  input wire        I_SYS_CLK,
  input wire        I_RST_N,
  input wire        I_CE,
  input wire [5:0]  I_ADDR,
  input wire [15:0] I_WDATA,
  input wire        I_WR,
  input wire        I_RD,
  input wire [39:0] O_RDATA,
  input wire [15:0] O_CONV_SETUP,
  input wire        O_CONV_ENABLE,
  input wire [95:0] O_LIMITS
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  // accepted strobes
  wire rd = I_RD && I_CE;
  wire wr = I_WR && I_CE;
  property p_idle; I_CE && !I_RD |=> O_RDATA == 40'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero");
  property p_ident; rd && I_ADDR == 6'h3E |=> O_RDATA == {24'h0, `PMRM_IDENT_CODE}; endproperty
  a_ident: assert property (p_ident) else $error("identity wrong");
  property p_setup; rd && I_ADDR == 6'h00 |=> O_RDATA[15:14] == 2'h0 && O_RDATA[5:0] == 6'h10;
  endproperty
  a_setup: assert property (p_setup) else $error("setup fixed bits wrong");
  property p_temp; rd && I_ADDR == 6'h06 |=> O_RDATA[39:16] == 24'h0 && O_RDATA[3:0] == 4'h0;
  endproperty
  a_temp: assert property (p_temp) else $error("temperature width wrong");
  property p_soft; wr && I_ADDR == 6'h00 && I_WDATA[15] |=> ##2
    (O_CONV_SETUP == 16'hFB68 && O_LIMITS == 96'h0 && !O_CONV_ENABLE); endproperty
  a_soft: assert property (p_soft) else $error("soft reset incomplete");
  property p_conv; wr && I_ADDR == 6'h01 ##1 I_CE |=> O_CONV_SETUP == $past(I_WDATA, 2);
  endproperty
  a_conv: assert property (p_conv) else $error("converter setup not written");
  property p_ro; wr && I_ADDR == 6'h3E |=> $stable(O_LIMITS) && $stable(O_CONV_SETUP); endproperty
  a_ro: assert property (p_ro) else $error("read-only write changed state");
  property p_start; wr && I_ADDR == 6'h00 && !I_WDATA[15] && I_WDATA[13:6] != 8'h0
    |=> ##1 !O_CONV_ENABLE [*8]; endproperty
  a_start: assert property (p_start) else $error("enable before delay");
  c_soft: cover property (wr && I_ADDR == 6'h00 && I_WDATA[15]);
  c_ident: cover property (rd && I_ADDR == 6'h3E);
  c_enable: cover property ($rose(O_CONV_ENABLE));
endmodule // pmrm_monitor
bind pmrm_top pmrm_monitor u_mon (.I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .O_CONV_SETUP(O_CONV_SETUP), .O_CONV_ENABLE(O_CONV_ENABLE), .O_LIMITS(O_LIMITS));

// ==== verification/pmrm_host.sv ====
// register bus host model
`timescale 1ns/10ps
module pmrm_host (
  input  wire        i_clk,
  output reg  [5:0]  o_addr,
  output reg  [15:0] o_wdata,
  output reg         o_wr,
  output reg         o_rd,
  input  wire [39:0] i_rdata
);
  initial begin
    o_addr = 6'h00;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // one write cycle, then an idle cycle; the address is driven as given, read-only ones included
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
    @(posedge i_clk);
  endtask
  // one read cycle, data taken in the following cycle
  task automatic rd(input logic [5:0] a, output logic [39:0] q);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    @(posedge i_clk);
    q = i_rdata;
  endtask
endmodule // pmrm_host

// ==== verification/tb_power_monitor_register_map.sv ====
// self-checking bench for the register map
`timescale 1ns/10ps
`include "pmrm_consts.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_power_monitor_register_map;
  logic        clk = 0, rst_n = 0, ce = 1, smp = 0, wr, rd, en_o;
  logic [5:0]  addr;
  logic [15:0] wdata, vb = 0, tp = 0, cu = 0, ft = 0, conv, r;
  logic [23:0] pw = 0;
  logic [39:0] ei = 0, ci = 0, q, rdata;
  logic [95:0] lim;
  logic [39:0] mdl [0:63];
  logic [31:0] seed = 32'h1A93;
  int          n_fail = 0, total_checks = 0, cyc = 0;
  pmrm_top u_dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .I_BUS_VOLTAGE_RESULT(vb), .I_TEMP(tp), .I_CURR(cu), .I_POWER(pw),
    .I_ENERGY_INC(ei), .I_CHARGE_INC(ci), .I_SAMPLE(smp), .I_FAULT(ft), .O_RDATA(rdata),
    .O_CONV_SETUP(conv), .O_CONV_ENABLE(en_o), .O_LIMITS(lim));
  pmrm_host u_host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
    .i_rdata(rdata));
  // clock and hang guard
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // model back to defaults
  task automatic mreset();
    foreach (mdl[i]) mdl[i] = 40'h0;
    mdl[0] = 40'h10;
    mdl[1] = 40'hFB68;
    mdl[62] = {24'h0, `PMRM_IDENT_CODE};
  endtask
  // read every address and compare with the model
  task automatic check_all();
    for (int a = 0; a < 64; a++) begin
      u_host.rd(a[5:0], q);
      `CHK(q, mdl[a])
    end
    `CHK(conv, mdl[1][15:0])
    for (int k = 0; k < 6; k++) `CHK(lim[16*k+:16], mdl[12+k][15:0])
  endtask
  task automatic write_limits();
    for (int k = 0; k < 6; k++) begin
      r = xs();
      u_host.wr(6'h0C + k[5:0], r);
      mdl[12+k] = {24'h0, r};
    end
  endtask
  task automatic summarize();
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    mreset();
    check_all();
    r = xs();
    u_host.wr(6'h01, r);
    mdl[1] = {24'h0, r};
    write_limits();
    u_host.wr(6'h3E, 16'hFFFF);
    check_all();
    u_host.wr(6'h00, 16'h0040);
    u_host.rd(6'h00, q);
    `CHK(q, 40'h50)
    repeat (50) @(posedge clk);
    `CHK(en_o, 1'b0)
    u_host.wr(6'h00, 16'h0000);
    repeat (4) @(posedge clk);
    `CHK(en_o, 1'b1)
    for (int s = 0; s < 2; s++) begin
      r = xs();
      vb <= r;
      tp <= ~r;
      cu <= r ^ 16'h5A3C;
      pw <= {r[7:0], r};
      ft <= r ^ 16'h0F0F;
      ei <= {8'h0, xs()};
      ci <= {8'h0, xs()};
      smp <= 1'b1;
      @(posedge clk);
      smp <= 1'b0;
      mdl[5] = {24'h0, vb};
      mdl[6] = {24'h0, tp & 16'hFFF0};
      mdl[7] = {24'h0, cu};
      mdl[8] = {16'h0, pw};
      mdl[11] = {24'h0, ft};
      mdl[9] += ei;
      mdl[10] += ci;
      @(posedge clk);
    end
    check_all();
    u_host.wr(6'h00, 16'h4000);
    mdl[9] = 40'h0;
    mdl[10] = 40'h0;
    check_all();
    ce <= 1'b0;
    u_host.wr(6'h01, ~mdl[1][15:0]);
    ce <= 1'b1;
    `CHK(conv, mdl[1][15:0])
    u_host.wr(6'h00, 16'h8000);
    mreset();
    @(posedge clk);
    check_all();
    write_limits();
    check_all();
    // power cycle in mid-run: limits must come back at their defaults
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    mreset();
    check_all();
    summarize();
  end
endmodule // tb_power_monitor_register_map
